//--- testbench/sfb_prog_model.sv
// Purpose: Stand-in for the user program: scan ends and control outputs
// Assumes: One scan lasts SCAN_P clock cycles
// Notes:   Controls pass through one register like an output image
`timescale 1ns/1ps
module sfb_prog_model
  import sfb_pkg::*;
#(
  parameter int unsigned SCAN_P = 8
) (
  // Clock and reset
  input  wire logic        clk_in,
  input  wire logic        rst_in,
  // Requests from the bench
  input  wire logic        scan_on_in,
  input  wire sfb_ctl_type ctl_req_in,
  // Program outputs
  output logic             scan_end_out,
  output sfb_ctl_type      ctl_out
);
  logic [15:0] cnt;

  always_ff @(posedge clk_in) begin
    ctl_out <= ctl_req_in;
    if (rst_in || !scan_on_in) begin
      cnt          <= 16'h0;
      scan_end_out <= 1'h0;
    end else begin
      cnt          <= (cnt == SCAN_P - 1) ? 16'h0 : cnt + 16'h1;
      scan_end_out <= (cnt == SCAN_P - 1);
    end
  end
endmodule

//--- testbench/sfb_top_sva.sv
// Purpose: Assertions on the ports of the system flag block
// Assumes: One clock, synchronous active-high reset
// Notes:   Flags are judged from the second edge after reset release
`timescale 1ns/1ps
module sfb_top_sva
  import sfb_pkg::*;
#(
  parameter int unsigned HALF_CYCLES_P = HALF_CYCLES
) (
  // Clock and reset
  input wire logic          clk_in,
  input wire logic          rst_in,
  // Controller state and status
  input wire logic          run_mode_in,
  input wire logic          scan_end_in,
  input wire logic          rtc_data_error_in,
  input wire logic          summer_time_in,
  input wire logic          fieldbus_comm_error_in,
  input wire logic          fieldbus_power_fail_in,
  input wire logic          modem_carrier_in,
  input wire logic          cell_network_ok_in,
  input wire logic          cell_remote_access_in,
  input wire sfb_ctl_type   ctl_in,
  // Outputs watched
  input wire sfb_flags_type flags_out,
  input wire logic          fieldbus_connect_out,
  input wire logic          backlight_on_out,
  input wire logic          screen_from_manager_out
);
  logic [31:0] cnt;
  logic        seen;
  logic        prev_tog;
  wire         tog_chg = flags_out[2] != prev_tog;

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  // Cycles since the last toggle edge
  always_ff @(posedge clk_in) begin
    prev_tog <= flags_out[2];
    if (rst_in) begin
      cnt  <= 32'h0;
      seen <= 1'h0;
    end else if (tog_chg) begin
      cnt  <= 32'h0;
      seen <= 1'h1;
    end else begin
      cnt <= cnt + 32'h1;
    end
  end

  a_const_flags: assert property (!$past(rst_in) |-> flags_out[1:0] == 2'h1)
    else $error("constant flags wrong");
  a_reserved_low: assert property (!$past(rst_in) |-> flags_out[10:9] == 2'h0)
    else $error("reserved flags not low");
  a_status_follow: assert property (!$past(rst_in) |->
    {flags_out[13:11], flags_out[6:3]} == $past({cell_remote_access_in, cell_network_ok_in,
    modem_carrier_in, fieldbus_power_fail_in, fieldbus_comm_error_in, summer_time_in,
    rtc_data_error_in})) else $error("status flags do not follow inputs");
  a_pulse_start: assert property (run_mode_in && !$past(run_mode_in) |=> flags_out[7])
    else $error("run entry pulse missing");
  a_pulse_end: assert property (flags_out[7] && scan_end_in |=> !flags_out[7])
    else $error("run entry pulse longer than one scan");
  a_pulse_hold: assert property (!run_mode_in |=> !flags_out[7])
    else $error("run entry pulse outside run");
  a_pulse_compl: assert property (!$past(rst_in) |-> flags_out[8] == !flags_out[7])
    else $error("low pulse not complement");
  a_toggle_period: assert property (seen && tog_chg |-> cnt == HALF_CYCLES_P - 1)
    else $error("toggle period wrong");
  a_bus_disconnect: assert property (!$past(rst_in) |->
    fieldbus_connect_out == !$past(ctl_in.ctl_fieldbus_disconnect))
    else $error("fieldbus connection wrong");
  a_force_on: assert property (ctl_in.ctl_backlight_force_on |=> backlight_on_out)
    else $error("forced backlight not lit");
  a_force_off: assert property (ctl_in.ctl_backlight_force_off &&
    !ctl_in.ctl_backlight_force_on |=> !backlight_on_out) else $error("backlight not dark");
  a_screen_src: assert property (!$past(rst_in) |->
    screen_from_manager_out == $past(ctl_in.ctl_screen_source_select))
    else $error("screen source wrong");

  c_run_pulse: cover property (flags_out[7] && scan_end_in);
  c_both_forces: cover property (ctl_in.ctl_backlight_force_on && ctl_in.ctl_backlight_force_off);
  c_toggle: cover property (seen && tog_chg);
endmodule

bind sfb_top sfb_top_sva #(.HALF_CYCLES_P(HALF_CYCLES_P)) i_sva (
  .clk_in(clk_in), .rst_in(rst_in), .run_mode_in(run_mode_in), .scan_end_in(scan_end_in),
  .rtc_data_error_in(rtc_data_error_in), .summer_time_in(summer_time_in),
  .fieldbus_comm_error_in(fieldbus_comm_error_in),
  .fieldbus_power_fail_in(fieldbus_power_fail_in), .modem_carrier_in(modem_carrier_in),
  .cell_network_ok_in(cell_network_ok_in), .cell_remote_access_in(cell_remote_access_in),
  .ctl_in(ctl_in), .flags_out(flags_out), .fieldbus_connect_out(fieldbus_connect_out),
  .backlight_on_out(backlight_on_out), .screen_from_manager_out(screen_from_manager_out));

//--- testbench/tb_sfb_top.sv
// Purpose: Self-checking bench for the system flag block
// Assumes: Toggle half period shortened to HC cycles
// Notes:   Bus handshakes are judged at the negedge before each edge
`timescale 1ns/1ps
module tb_sfb_top
  import sfb_pkg::*;
;
  localparam int unsigned HC   = 10;
  localparam int unsigned SCAN = 8;
  logic clk_in = 0, rst_in = 1, run_mode_in = 0, user_activity_in = 0, scan_on = 0;
  logic [6:0] st = 7'h0;
  sfb_ctl_type ctl_req = 4'h0;
  sfb_ctl_type ctl_in;
  logic scan_end_in, fieldbus_connect_out, backlight_on_out, screen_from_manager_out, tg;
  sfb_flags_type flags_out;
  logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
  logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  int num_errors = 0;
  int checked = 0;

  always #50 clk_in = ~clk_in;

  sfb_prog_model #(.SCAN_P(SCAN)) i_prog (.clk_in(clk_in), .rst_in(rst_in),
    .scan_on_in(scan_on), .ctl_req_in(ctl_req), .scan_end_out(scan_end_in), .ctl_out(ctl_in));

  sfb_top #(.HALF_CYCLES_P(HC)) i_dut (.clk_in(clk_in), .rst_in(rst_in),
    .run_mode_in(run_mode_in), .scan_end_in(scan_end_in), .user_activity_in(user_activity_in),
    .rtc_data_error_in(st[0]), .summer_time_in(st[1]), .fieldbus_comm_error_in(st[2]),
    .fieldbus_power_fail_in(st[3]), .modem_carrier_in(st[4]), .cell_network_ok_in(st[5]),
    .cell_remote_access_in(st[6]), .ctl_in(ctl_in), .flags_out(flags_out),
    .fieldbus_connect_out(fieldbus_connect_out), .backlight_on_out(backlight_on_out),
    .screen_from_manager_out(screen_from_manager_out), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awprot(3'h0), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arprot(3'h0),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic close_out();
    if (num_errors == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge clk_in);
    @(negedge clk_in);
  endtask

  task automatic axi_write(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
    logic ah, wh, bh;
    int n;
    n = 0;
    bh = 0;
    @(posedge clk_in);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid  <= 1'h1;
    s_axi_bready  <= 1'h1;
    while (!bh && n < 100) begin
      @(negedge clk_in);
      ah = s_axi_awvalid & s_axi_awready;
      wh = s_axi_wvalid & s_axi_wready;
      bh = s_axi_bvalid;
      r  = s_axi_bresp;
      @(posedge clk_in);
      if (ah) s_axi_awvalid <= 1'h0;
      if (wh) s_axi_wvalid <= 1'h0;
      n++;
    end
    s_axi_bready <= 1'h0;
  endtask

  task automatic axi_read(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ah, rh;
    int n;
    n = 0;
    rh = 0;
    @(posedge clk_in);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready  <= 1'h1;
    while (!rh && n < 100) begin
      @(negedge clk_in);
      ah = s_axi_arvalid & s_axi_arready;
      rh = s_axi_rvalid;
      d  = s_axi_rdata;
      r  = s_axi_rresp;
      @(posedge clk_in);
      if (ah) s_axi_arvalid <= 1'h0;
      n++;
    end
    s_axi_rready <= 1'h0;
  endtask

  task automatic activity();
    @(posedge clk_in);
    user_activity_in <= 1'h1;
    @(posedge clk_in);
    user_activity_in <= 1'h0;
  endtask

  initial begin
    repeat (20000) @(posedge clk_in);
    num_errors++;
    close_out();
  end

  initial begin
    repeat (16) @(posedge clk_in);
    rst_in <= 1'h0;
    settle(3);
    check("const", flags_out[1:0], 2'h1);
    check("reserved", flags_out[10:9], 2'h0);
    // Four control combinations, both forces last
    for (int i = 0; i < 4; i++) begin
      @(posedge clk_in);
      ctl_req <= {i[1], i[1], i[0], i[0]};
      settle(3);
      check("backlight", backlight_on_out, i[1] | !i[0]);
      check("connect", fieldbus_connect_out, !i[0]);
      check("screen", screen_from_manager_out, i[1]);
    end
    @(posedge clk_in);
    ctl_req <= 4'h0;
    // Walking one over the status inputs
    for (int i = 0; i < 7; i++) begin
      @(posedge clk_in);
      st <= 7'h01 << i;
      settle(2);
      check("status", {flags_out[13:11], flags_out[6:3]}, st);
    end
    @(posedge clk_in);
    st <= 7'h0;
    settle(1);
    tg = flags_out[2];
    // Align to a flip, then expect the next one exactly HC edges later
    while (flags_out[2] === tg) settle(0);
    settle(HC - 1);
    check("toggle_half", flags_out[2], !tg);
    settle(1);
    check("toggle_full", flags_out[2], tg);
    // Run entry pulse, ended by the first scan end
    @(posedge clk_in);
    run_mode_in <= 1'h1;
    settle(2);
    check("pulse_on", flags_out[8:7], 2'h1);
    @(posedge clk_in);
    scan_on <= 1'h1;
    settle(SCAN + 2);
    check("pulse_off", flags_out[8:7], 2'h2);
    // Registers
    axi_read(OFS_LIGHT_DELAY, rd, rsp);
    check("delay_reset", rd, {16'h0, RST_LIGHT_DELAY});
    check("delay_resp", rsp, RESP_OKAY);
    axi_read(OFS_FLAGS, rd, rsp);
    check("flags_reg", rd & 32'hFFFFFFFB, 32'h00000101);
    axi_write(OFS_FLAGS, 32'h0000FFFF, rsp);
    check("flags_ro", rsp, RESP_SLVERR);
    // Low address bits are ignored: byte 2 lands in word 0
    axi_read(4'h2, rd, rsp);
    check("unaligned_resp", rsp, RESP_OKAY);
    check("unaligned_data", rd, {16'h0, RST_LIGHT_DELAY});
    axi_write(OFS_LIGHT_DELAY, 32'h00000002, rsp);
    check("delay_wr_resp", rsp, RESP_OKAY);
    axi_read(OFS_LIGHT_DELAY, rd, rsp);
    check("delay_rw", rd, 32'h00000002);
    // Automatic backlight with a two second delay, at least one full second lit
    activity();
    settle(3);
    check("auto_lit", backlight_on_out, 1'h1);
    settle(70);
    check("auto_dark", backlight_on_out, 1'h0);
    axi_write(OFS_LIGHT_DELAY, 32'h00000000, rsp);
    activity();
    settle(3);
    check("zero_delay", backlight_on_out, 1'h0);
    axi_read(OFS_OUTPUTS, rd, rsp);
    check("outputs_reg", rd, 32'h00000001);
    axi_read(OFS_INPUTS, rd, rsp);
    check("inputs_reg", rd, 32'h00000010);
    close_out();
  end
endmodule

//--- verilog/sfb_pkg.sv
// Purpose: Shared constants and types for the system flag block
// Assumes: 10 MHz clock, AXI4-Lite register access with 32-bit data
// Notes:   Offsets are byte addresses of aligned words
package sfb_pkg;

  // Clock and timing
  localparam int unsigned CLK_HZ          = 10000000;
  localparam int unsigned HALF_PERIOD_MS  = 500;
  localparam int unsigned HALF_CYCLES     = (CLK_HZ / 1000) * HALF_PERIOD_MS;

  // Bus geometry
  localparam int unsigned ADDR_W          = 4;
  localparam int unsigned DATA_W          = 32;
  localparam int unsigned FLAG_COUNT      = 14;
  localparam int unsigned DELAY_W         = 16;

  // Register offsets
  localparam logic [ADDR_W-1:0] OFS_LIGHT_DELAY = 4'h0;
  localparam logic [ADDR_W-1:0] OFS_FLAGS       = 4'h4;
  localparam logic [ADDR_W-1:0] OFS_OUTPUTS     = 4'h8;
  localparam logic [ADDR_W-1:0] OFS_INPUTS      = 4'hC;

  // Reset values
  localparam logic [DELAY_W-1:0] RST_LIGHT_DELAY = 16'h000A;
  localparam logic [FLAG_COUNT-1:0] RST_FLAGS    = 14'h0101;

  // Field positions of the outputs status word
  localparam int unsigned POS_FIELDBUS_CONNECT = 0;
  localparam int unsigned POS_BACKLIGHT_ON     = 1;
  localparam int unsigned POS_SCREEN_MANAGER   = 2;
  localparam int unsigned POS_AUTO_LIT         = 3;

  // Field positions of the inputs status word
  localparam int unsigned POS_CTL_DISCONNECT   = 0;
  localparam int unsigned POS_CTL_FORCE_OFF    = 1;
  localparam int unsigned POS_CTL_FORCE_ON     = 2;
  localparam int unsigned POS_CTL_SCREEN       = 3;
  localparam int unsigned POS_RUN_MODE         = 4;

  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Fourteen system flags, first flag in bit 0
  typedef struct packed {
    logic flag_cell_remote_access;
    logic flag_cell_network_ok;
    logic flag_modem_carrier;
    logic flag_reserved_b;
    logic flag_reserved_a;
    logic flag_run_entry_pulse_low;
    logic flag_run_entry_pulse_high;
    logic flag_fieldbus_power_fail;
    logic flag_fieldbus_comm_error;
    logic flag_summer_time_active;
    logic flag_clock_data_error;
    logic flag_half_second_toggle;
    logic flag_const_low;
    logic flag_const_high;
  } sfb_flags_type;

  // Special control outputs driven by the user program
  typedef struct packed {
    logic ctl_screen_source_select;
    logic ctl_backlight_force_on;
    logic ctl_backlight_force_off;
    logic ctl_fieldbus_disconnect;
  } sfb_ctl_type;

  // Run-entry sequence
  typedef enum logic [2:0] {
    ST_STOP  = 3'h1,
    ST_PULSE = 3'h2,
    ST_RUN   = 3'h4
  } sfb_run_state_type;

endpackage

//--- verilog/sfb_top.sv
// Purpose: System flag bits and special control outputs of the controller
// Assumes: All inputs synchronous to clk_in; scan_end_in pulses once per scan
// Notes:   Registers reached over AXI4-Lite; one clock, synchronous reset
//
// The register addresses and the AXI4-Lite register port are this design's own decisions.
`timescale 1ns/1ps

module sfb_top
  import sfb_pkg::*;
#(
  parameter int unsigned HALF_CYCLES_P = HALF_CYCLES
) (
  // Clock and reset
  input  wire logic                clk_in,
  input  wire logic                rst_in,
  // Controller state
  input  wire logic                run_mode_in,
  input  wire logic                scan_end_in,
  input  wire logic                user_activity_in,
  // Status sources
  input  wire logic                rtc_data_error_in,
  input  wire logic                summer_time_in,
  input  wire logic                fieldbus_comm_error_in,
  input  wire logic                fieldbus_power_fail_in,
  input  wire logic                modem_carrier_in,
  input  wire logic                cell_network_ok_in,
  input  wire logic                cell_remote_access_in,
  // Control outputs from the user program
  input  wire sfb_ctl_type         ctl_in,
  // Flags to the user program
  output sfb_flags_type            flags_out,
  // Effects on the device
  output logic                     fieldbus_connect_out,
  output logic                     backlight_on_out,
  output logic                     screen_from_manager_out,
  // AXI4-Lite write address
  input  wire logic [ADDR_W-1:0]   s_axi_awaddr,
  input  wire logic [2:0]          s_axi_awprot,
  input  wire logic                s_axi_awvalid,
  output logic                     s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [DATA_W-1:0]   s_axi_wdata,
  input  wire logic [3:0]          s_axi_wstrb,
  input  wire logic                s_axi_wvalid,
  output logic                     s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]               s_axi_bresp,
  output logic                     s_axi_bvalid,
  input  wire logic                s_axi_bready,
  // AXI4-Lite read address
  input  wire logic [ADDR_W-1:0]   s_axi_araddr,
  input  wire logic [2:0]          s_axi_arprot,
  input  wire logic                s_axi_arvalid,
  output logic                     s_axi_arready,
  // AXI4-Lite read data
  output logic [DATA_W-1:0]        s_axi_rdata,
  output logic [1:0]               s_axi_rresp,
  output logic                     s_axi_rvalid,
  input  wire logic                s_axi_rready
);

  // Half-second divider
  logic [22:0]              half_count;
  logic                     half_tick;
  logic                     toggle;
  logic                     second_tick;

  // Run-entry sequence
  sfb_run_state_type        run_state;
  sfb_run_state_type        next_run_state;
  logic                     run_prev;
  logic                     run_rise;

  // Backlight timing
  logic [DELAY_W-1:0]       light_delay;
  logic [DELAY_W-1:0]       idle_seconds;
  logic                     auto_lit;
  logic                     next_backlight;

  // Flag assembly
  sfb_flags_type            next_flags;

  // Bus state
  logic                     aw_held;
  logic                     w_held;
  logic [ADDR_W-1:0]        aw_addr;
  logic [DATA_W-1:0]        w_data;
  logic [3:0]               w_strb;
  logic                     aw_take;
  logic                     w_take;
  logic                     ar_take;
  logic                     write_fire;
  logic                     wr_hit_delay;
  logic                     rd_known;
  logic [DATA_W-1:0]        rd_word;
  logic [DELAY_W-1:0]       next_delay;
  logic [DATA_W-1:0]        outputs_word;
  logic [DATA_W-1:0]        inputs_word;

  // ---------------------------------------------------------------
  // Half-second enable and square wave
  // ---------------------------------------------------------------
  assign half_tick   = (half_count == 23'(HALF_CYCLES_P - 1));
  assign second_tick = half_tick & toggle;

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      half_count <= 23'h000000;
      toggle     <= 1'b0;
    end else if (half_tick) begin
      half_count <= 23'h000000;
      toggle     <= ~toggle;
    end else begin
      half_count <= half_count + 23'h000001;
    end
  end

  // ---------------------------------------------------------------
  // Stop-to-run detection, pulse lasts the first scan
  // ---------------------------------------------------------------
  assign run_rise = run_mode_in & ~run_prev;

  always_comb begin
    next_run_state = run_state;
    unique case (run_state)
      ST_STOP: begin
        if (run_rise) begin
          next_run_state = ST_PULSE;
        end
      end
      ST_PULSE: begin
        if (!run_mode_in) begin
          next_run_state = ST_STOP;
        end else if (scan_end_in) begin
          next_run_state = ST_RUN;
        end
      end
      ST_RUN: begin
        if (!run_mode_in) begin
          next_run_state = ST_STOP;
        end
      end
      default: begin
        next_run_state = ST_STOP;
      end
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      run_state <= ST_STOP;
      run_prev  <= 1'b0;
    end else begin
      run_state <= next_run_state;
      run_prev  <= run_mode_in;
    end
  end

  // ---------------------------------------------------------------
  // Flag word
  // ---------------------------------------------------------------
  always_comb begin
    next_flags                           = '0;
    next_flags.flag_const_high           = 1'b1;
    next_flags.flag_const_low            = 1'b0;
    next_flags.flag_half_second_toggle   = toggle;
    next_flags.flag_clock_data_error     = rtc_data_error_in;
    next_flags.flag_summer_time_active   = summer_time_in;
    next_flags.flag_fieldbus_comm_error  = fieldbus_comm_error_in;
    next_flags.flag_fieldbus_power_fail  = fieldbus_power_fail_in;
    next_flags.flag_run_entry_pulse_high = (next_run_state == ST_PULSE);
    next_flags.flag_run_entry_pulse_low  = (next_run_state != ST_PULSE);
    next_flags.flag_reserved_a           = 1'b0;
    next_flags.flag_reserved_b           = 1'b0;
    next_flags.flag_modem_carrier        = modem_carrier_in;
    next_flags.flag_cell_network_ok      = cell_network_ok_in;
    next_flags.flag_cell_remote_access   = cell_remote_access_in;
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      flags_out <= sfb_flags_type'(RST_FLAGS);
    end else begin
      flags_out <= next_flags;
    end
  end

  // ---------------------------------------------------------------
  // Backlight: idle timer against configured delay
  // ---------------------------------------------------------------
  assign auto_lit = (idle_seconds < light_delay);

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      idle_seconds <= 16'h0000;
    end else if (user_activity_in) begin
      idle_seconds <= 16'h0000;
    end else if (second_tick && auto_lit) begin
      idle_seconds <= idle_seconds + 16'h0001;
    end
  end

  // Force-on wins over force-off
  assign next_backlight = ctl_in.ctl_backlight_force_on
                        | (~ctl_in.ctl_backlight_force_off & auto_lit);

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      backlight_on_out        <= 1'b1;
      fieldbus_connect_out    <= 1'b1;
      screen_from_manager_out <= 1'b0;
    end else begin
      backlight_on_out        <= next_backlight;
      fieldbus_connect_out    <= ~ctl_in.ctl_fieldbus_disconnect;
      screen_from_manager_out <= ctl_in.ctl_screen_source_select;
    end
  end

  // ---------------------------------------------------------------
  // AXI4-Lite write path
  // ---------------------------------------------------------------
  assign s_axi_awready = ~aw_held & ~s_axi_bvalid;
  assign s_axi_wready  = ~w_held & ~s_axi_bvalid;
  assign aw_take       = s_axi_awvalid & s_axi_awready;
  assign w_take        = s_axi_wvalid & s_axi_wready;
  assign write_fire    = aw_held & w_held & ~s_axi_bvalid;
  assign wr_hit_delay  = write_fire & (aw_addr == OFS_LIGHT_DELAY);

  assign next_delay[7:0]  = w_strb[0] ? w_data[7:0]  : light_delay[7:0];
  assign next_delay[15:8] = w_strb[1] ? w_data[15:8] : light_delay[15:8];

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      aw_held <= 1'b0;
      aw_addr <= 4'h0;
    end else if (aw_take) begin
      aw_held <= 1'b1;
      aw_addr <= {s_axi_awaddr[ADDR_W-1:2], 2'h0};
    end else if (write_fire) begin
      aw_held <= 1'b0;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      w_held <= 1'b0;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
    end else if (w_take) begin
      w_held <= 1'b1;
      w_data <= s_axi_wdata;
      w_strb <= s_axi_wstrb;
    end else if (write_fire) begin
      w_held <= 1'b0;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      light_delay <= RST_LIGHT_DELAY;
    end else if (wr_hit_delay) begin
      light_delay <= next_delay;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (write_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_hit_delay ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // AXI4-Lite read path
  // ---------------------------------------------------------------
  assign s_axi_arready = ~s_axi_rvalid;
  assign ar_take       = s_axi_arvalid & s_axi_arready;

  // Status words built from the field positions
  always_comb begin
    outputs_word                       = 32'h00000000;
    outputs_word[POS_FIELDBUS_CONNECT] = fieldbus_connect_out;
    outputs_word[POS_BACKLIGHT_ON]     = backlight_on_out;
    outputs_word[POS_SCREEN_MANAGER]   = screen_from_manager_out;
    outputs_word[POS_AUTO_LIT]         = auto_lit;
  end

  always_comb begin
    inputs_word                     = 32'h00000000;
    inputs_word[POS_CTL_DISCONNECT] = ctl_in.ctl_fieldbus_disconnect;
    inputs_word[POS_CTL_FORCE_OFF]  = ctl_in.ctl_backlight_force_off;
    inputs_word[POS_CTL_FORCE_ON]   = ctl_in.ctl_backlight_force_on;
    inputs_word[POS_CTL_SCREEN]     = ctl_in.ctl_screen_source_select;
    inputs_word[POS_RUN_MODE]       = run_mode_in;
  end

  always_comb begin
    rd_known = 1'b1;
    unique case ({s_axi_araddr[ADDR_W-1:2], 2'h0})
      OFS_LIGHT_DELAY: rd_word = DATA_W'(light_delay);
      OFS_FLAGS:       rd_word = DATA_W'(flags_out);
      OFS_OUTPUTS:     rd_word = outputs_word;
      OFS_INPUTS:      rd_word = inputs_word;
      default: begin
        rd_word  = 32'h00000000;
        rd_known = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= RESP_OKAY;
    end else if (ar_take) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_word;
      s_axi_rresp  <= rd_known ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule
